//--- src/hbgc_core.sv
// Overview of operation
// - Gate drivers leave standby only while enable is high.
// - Enable low gives standby: gates resistive, fault flag released (tristate).
// - Speed low: direction 0 drives H2/L1, direction 1 drives H1/L2.
// - Speed high brakes: both low gates source, both high gates sink.
// - Fault flag is high in every fault-free enabled state, braking included.
// - Overtemperature sinks all gates, serial line off, flag low until cleared.
// - Overvoltage sinks all gates, serial line off, flag low.
// - Undervoltage keeps all gates sinking and flag low.
// - Active high gate with node below threshold too long is latched off.
// - Active low gate with node above threshold too long is latched off.
// - Short latch holds, flag low, until direction or speed input changes.
// - Short latch affects only its own transistor; others follow inputs.
// - Flag low on any of overtemperature, supply faults or short shutdown.
// - Boost switch toggles at 100 kHz, 50 percent duty while active.
// - Boost starts below lower threshold, stops above upper threshold.
//
// Implementation choices: the Avalon-MM register port and the address map.
`include "hbgc_params.svh"

module hbgc_core #(
   parameter int SHORT_QUAL_CYC  = `HBGC_SHORT_QUAL_CYC,
   parameter int BOOST_PERIOD    = `HBGC_BOOST_PERIOD_CYC,
   parameter int BOOST_HIGH      = `HBGC_BOOST_HIGH_CYC
) (
   // Clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   // Avalon-MM slave
   input  wire logic [3:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [3:0]          avs_byteenable_i,
   output logic      [31:0]         avs_readdata_o,
   output logic                     avs_waitrequest_o,
   output logic      [1:0]          avs_response_o,
   // Analog monitor indications
   input  wire logic                overtemp_flag_i,
   input  wire logic                supply_high_flag_i,
   input  wire logic                supply_low_flag_i,
   input  wire logic                supply_below_boost_on_i,
   input  wire logic                supply_above_boost_off_i,
   input  wire logic                bridge_node_one_high_i,
   input  wire logic                bridge_node_two_high_i,
   // Gate drive
   output hbgc_pkg::hbgc_gates_s    gate_drive_o,
   output logic                     gate_resistive_o,
   output logic                     serial_line_off_o,
   // Open-drain fault flag and boost switch
   output logic                     fault_flag_out_o,
   output logic                     fault_flag_out_oe_o,
   output logic                     upconverter_switch_o,
   output logic                     upconverter_switch_oe_o,
   // Interrupt
   output logic                     irq_o
);
   import hbgc_pkg::*;

   localparam int QW = $clog2(SHORT_QUAL_CYC + 1);
   localparam int BW = $clog2(BOOST_PERIOD + 1);

   logic [2:0]             ctrl_r;
   logic [`HBGC_EV_W-1:0]  irq_stat_r;
   logic [`HBGC_EV_W-1:0]  irq_mask_r;
   logic [`HBGC_EV_W-1:0]  ev_lvl;
   logic [`HBGC_EV_W-1:0]  ev_lvl_q_r;
   logic                   en;
   logic                   dir;
   logic                   pwm;
   logic                   dir_q_r;
   logic                   pwm_q_r;
   logic                   input_chg;
   logic [1:0]             node_s1_r;
   logic [1:0]             node_s2_r;
   hbgc_gates_s            want;
   hbgc_gates_s            short_r;
   logic [3:0]             short_cond;
   logic                   global_fault;
   logic                   any_short;
   hbgc_mode_e             mode;
   hbgc_gates_s            gate_r;
   logic                   fault_low_r;
   logic                   boost_on_r;
   logic [BW-1:0]          boost_cnt_r;
   logic                   boost_sw_r;
   logic                   wr_hit;
   logic                   rd_pend_r;
   logic [QW-1:0]          qual_cnt_r [4];

   assign en  = ctrl_r[`HBGC_CTRL_EN_BIT];
   assign dir = ctrl_r[`HBGC_CTRL_DIR_BIT];
   assign pwm = ctrl_r[`HBGC_CTRL_PWM_BIT];

   // Register bus: a write finishes at once, a read waits one cycle so registered data stands at the answer.
   assign avs_waitrequest_o = avs_read_i && !rd_pend_r;
   assign avs_response_o    = 2'b00;
   assign wr_hit            = avs_write_i && avs_byteenable_i[0];

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_r <= `HBGC_CTRL_RST;
      end else if (wr_hit && avs_address_i == `HBGC_REG_CTRL) begin
         ctrl_r <= avs_writedata_i[2:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_mask_r <= `HBGC_MASK_RST;
      end else if (wr_hit && avs_address_i == `HBGC_REG_IRQ_MASK) begin
         irq_mask_r <= avs_writedata_i[`HBGC_EV_W-1:0];
      end
   end

   // Rising event edges set sticky bits; a set in the clearing cycle wins.
   assign ev_lvl = {any_short, supply_low_flag_i & en, supply_high_flag_i & en, overtemp_flag_i & en};

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ev_lvl_q_r <= 4'h0;
         irq_stat_r <= 4'h0;
      end else begin
         ev_lvl_q_r <= ev_lvl;
         if (wr_hit && avs_address_i == `HBGC_REG_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~avs_writedata_i[`HBGC_EV_W-1:0]) | (ev_lvl & ~ev_lvl_q_r);
         end else begin
            irq_stat_r <= irq_stat_r | (ev_lvl & ~ev_lvl_q_r);
         end
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rd_pend_r <= 1'b0;
      end else begin
         rd_pend_r <= avs_read_i && !rd_pend_r;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && !rd_pend_r) begin
         unique case (avs_address_i)
            `HBGC_REG_CTRL:     avs_readdata_o <= {29'h0, ctrl_r};
            `HBGC_REG_STATUS:   avs_readdata_o <= {20'h0, gate_r, 2'h0, boost_on_r, fault_low_r,
                                                   overtemp_flag_i, supply_high_flag_i, supply_low_flag_i, any_short};
            `HBGC_REG_IRQ_STAT: avs_readdata_o <= {28'h0, irq_stat_r};
            `HBGC_REG_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask_r};
            default:            avs_readdata_o <= 32'h0;
         endcase
      end
   end

   // Input change detection clears short latches.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dir_q_r <= 1'b1;
         pwm_q_r <= 1'b1;
      end else begin
         dir_q_r <= dir;
         pwm_q_r <= pwm;
      end
   end
   assign input_chg = (dir != dir_q_r) || (pwm != pwm_q_r);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         node_s1_r <= 2'b00;
         node_s2_r <= 2'b00;
      end else begin
         node_s1_r <= {node_s1_r[0], bridge_node_one_high_i};
         node_s2_r <= {node_s2_r[0], bridge_node_two_high_i};
      end
   end

   always_comb begin
      if (pwm) begin
         want = '{high_one: 1'b0, low_one: 1'b1, high_two: 1'b0, low_two: 1'b1};
      end else if (dir) begin
         want = '{high_one: 1'b1, low_one: 1'b0, high_two: 1'b0, low_two: 1'b1};
      end else begin
         want = '{high_one: 1'b0, low_one: 1'b1, high_two: 1'b1, low_two: 1'b0};
      end
   end

   // high side sees node low; low side sees node high.
   assign short_cond[3] = gate_r.high_one & ~node_s1_r[1];
   assign short_cond[2] = gate_r.low_one  &  node_s1_r[1];
   assign short_cond[1] = gate_r.high_two & ~node_s2_r[1];
   assign short_cond[0] = gate_r.low_two  &  node_s2_r[1];

   generate
      for (genvar g = 0; g < 4; g++) begin : g_short
         always_ff @(posedge sys_clk_i) begin
            if (rst_i || !en || global_fault || input_chg || !short_cond[g]) begin
               qual_cnt_r[g] <= '0;
            end else if (qual_cnt_r[g] != QW'(SHORT_QUAL_CYC)) begin
               qual_cnt_r[g] <= qual_cnt_r[g] + QW'(1);
            end
         end
         always_ff @(posedge sys_clk_i) begin
            if (rst_i || !en || input_chg) begin
               short_r[g] <= 1'b0;
            end else if (qual_cnt_r[g] == QW'(SHORT_QUAL_CYC)) begin
               short_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign any_short    = |short_r;
   assign global_fault = overtemp_flag_i | supply_high_flag_i | supply_low_flag_i;

   always_comb begin
      if (!en) begin
         mode = HBGC_STANDBY;
      end else if (global_fault) begin
         mode = HBGC_FAULT;
      end else begin
         mode = HBGC_RUN;
      end
   end

   // a latch masks only its own gate.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         gate_r <= '0;
      end else begin
         unique case (mode)
            HBGC_STANDBY: gate_r <= '0;
            HBGC_FAULT:   gate_r <= '0;
            HBGC_RUN:     gate_r <= input_chg ? want : (want & ~short_r);
         endcase
      end
   end

   // fault flag low on any fault.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fault_low_r <= 1'b0;
      end else begin
         fault_low_r <= en && (global_fault || any_short);
      end
   end

   assign gate_drive_o = gate_r;
   // standby makes gates resistive and releases the flag.
   assign gate_resistive_o    = !en;
   // serial line off on overvoltage and overtemperature.
   assign serial_line_off_o   = en & (overtemp_flag_i | supply_high_flag_i);
   assign fault_flag_out_o    = 1'b0;
   assign fault_flag_out_oe_o = fault_low_r;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         boost_on_r <= 1'b0;
      end else if (supply_below_boost_on_i) begin
         boost_on_r <= 1'b1;
      end else if (supply_above_boost_off_i) begin
         boost_on_r <= 1'b0;
      end
   end

   // fixed-rate switch; the counter idles at zero when off.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !boost_on_r || boost_cnt_r == BW'(BOOST_PERIOD - 1)) begin
         boost_cnt_r <= '0;
      end else begin
         boost_cnt_r <= boost_cnt_r + BW'(1);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         boost_sw_r <= 1'b0;
      end else begin
         boost_sw_r <= boost_on_r && (boost_cnt_r < BW'(BOOST_HIGH));
      end
   end

   // Open drain: pulling low is the switch closed.
   assign upconverter_switch_o    = 1'b0;
   assign upconverter_switch_oe_o = boost_sw_r;

   // Assertions.
   standby_gates_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !en |=> gate_r == '0 && !fault_low_r)
      else $error("gates not off in standby");

   enable_drive_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && !global_fault && short_r == '0 |=> gate_r != '0)
      else $error("gates idle while enabled");

   fault_sink_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && overtemp_flag_i |=> gate_r == '0)
      else $error("gates active in overtemperature");

   ovp_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && supply_high_flag_i |=> fault_low_r && gate_r == '0)
      else $error("overvoltage not handled");

   uv_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && supply_low_flag_i |=> fault_low_r && gate_r == '0)
      else $error("undervoltage not handled");

   brake_decode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && pwm && !global_fault && short_r == '0 |=> gate_r == 4'b0101)
      else $error("brake decode wrong");

   dir_decode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && !pwm && dir && !global_fault && short_r == '0 |=> gate_r == 4'b1001)
      else $error("direction decode wrong");

   flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && !global_fault && !any_short |=> !fault_low_r)
      else $error("flag low without fault");

   short_latch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      short_r[3] && en && !input_chg |=> short_r[3])
      else $error("short latch dropped");

   short_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      input_chg |=> short_r == '0)
      else $error("short latch not cleared");

   short_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      short_r != '0 && !input_chg |=> (gate_r & $past(short_r)) == '0)
      else $error("shorted gate still driven");

   short_keep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && !global_fault && !pwm && !dir && !short_r.low_one |=> gate_r.low_one)
      else $error("healthy gate dropped by short");

   short_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      en && any_short |=> fault_low_r)
      else $error("short not flagged");

   boost_period_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      boost_on_r && boost_cnt_r == '0 && $past(boost_on_r) |=> boost_sw_r)
      else $error("boost phase wrong");

   boost_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      boost_on_r && boost_cnt_r == BW'(BOOST_HIGH) |=> !boost_sw_r)
      else $error("boost low phase wrong");

   boost_start_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      supply_below_boost_on_i |=> boost_on_r)
      else $error("boost not started");

   boost_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      supply_above_boost_off_i && !supply_below_boost_on_i |=> !boost_on_r)
      else $error("boost not stopped");

   brake_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) en && pwm && !global_fault);
   run_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) en && !pwm && !global_fault);
   fault_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) en && global_fault);
   short_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(any_short));
   boost_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(boost_sw_r));
endmodule

//--- inc/hbgc_params.svh
`ifndef HBGC_PARAMS_SVH
`define HBGC_PARAMS_SVH

// System clock in kHz (25 MHz).
`define HBGC_CLK_KHZ           25000
// Short qualification time in ns (typical figure).
`define HBGC_SHORT_QUAL_NS     10000
`define HBGC_SHORT_QUAL_CYC    ((`HBGC_SHORT_QUAL_NS * `HBGC_CLK_KHZ) / 1000000)
// Boost switch frequency in kHz and duty in percent.
`define HBGC_BOOST_KHZ         100
`define HBGC_BOOST_DUTY_PCT    50
`define HBGC_BOOST_PERIOD_CYC  (`HBGC_CLK_KHZ / `HBGC_BOOST_KHZ)
`define HBGC_BOOST_HIGH_CYC    ((`HBGC_BOOST_PERIOD_CYC * `HBGC_BOOST_DUTY_PCT) / 100)
// Wake-up interval in ns, kept for the host side.
`define HBGC_WAKE_NS           50000
`define HBGC_WAKE_CYC          ((`HBGC_WAKE_NS * `HBGC_CLK_KHZ) / 1000000)
// Register offsets.
`define HBGC_REG_CTRL          4'h0
`define HBGC_REG_STATUS        4'h4
`define HBGC_REG_IRQ_STAT      4'h8
`define HBGC_REG_IRQ_MASK      4'hC
// Control register fields.
`define HBGC_CTRL_EN_BIT       0
`define HBGC_CTRL_DIR_BIT      1
`define HBGC_CTRL_PWM_BIT      2
`define HBGC_CTRL_RST          3'h6
// Interrupt status and mask event fields.
`define HBGC_EV_OVERTEMP       0
`define HBGC_EV_SUPPLY_HIGH    1
`define HBGC_EV_SUPPLY_LOW     2
`define HBGC_EV_SHORT          3
`define HBGC_EV_W              4
`define HBGC_MASK_RST          4'h0

`endif

//--- inc/hbgc_pkg.sv
package hbgc_pkg;
   typedef struct packed {
      logic high_one;
      logic low_one;
      logic high_two;
      logic low_two;
   } hbgc_gates_s;

   typedef enum logic [1:0] {
      HBGC_STANDBY,
      HBGC_FAULT,
      HBGC_RUN
   } hbgc_mode_e;
endpackage

//--- dv/hbgc_bridge_model.sv
module hbgc_bridge_model (
   // Clock
   input  wire logic                  sys_clk_i,
   // Gate drive and injected shorts
   input  wire hbgc_pkg::hbgc_gates_s gates_i,
   input  wire logic [1:0]            short_gnd_i,
   input  wire logic [1:0]            short_bat_i,
   // Node comparators
   output logic                       node_one_high_o,
   output logic                       node_two_high_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import hbgc_pkg::*;
   logic float_r;

   // A node with both transistors off floats, so it never shows a held level.
   always_ff @(posedge sys_clk_i) begin
      float_r <= (float_r === 1'b1) ? 1'b0 : 1'b1;
   end

   assign node_one_high_o = short_gnd_i[0] ? 1'b0 : short_bat_i[0] ? 1'b1 :
                            gates_i.high_one ? 1'b1 : gates_i.low_one ? 1'b0 : float_r;
   assign node_two_high_o = short_gnd_i[1] ? 1'b0 : short_bat_i[1] ? 1'b1 :
                            gates_i.high_two ? 1'b1 : gates_i.low_two ? 1'b0 : float_r;
endmodule

//--- dv/hbgc_core_bench.sv
`include "hbgc_params.svh"
module hbgc_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import hbgc_pkg::*;
   localparam int QUAL  = 8;
   localparam int BPER  = 10;
   localparam int BHIGH = 5;
   localparam int LIMIT = 40000;
   logic        clk, rst, rd, wr, below, above, n1, n2, res, sl_off, fl_o, fl_oe, up_o, up_oe, irq, wreq;
   logic [3:0]  addr, be;
   logic [31:0] wdata, rdata;
   logic [1:0]  resp, sgnd, sbat;
   logic [2:0]  flt;
   hbgc_gates_s gates;
   int          failures, total_checks, cycles;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   hbgc_core #(.SHORT_QUAL_CYC(QUAL), .BOOST_PERIOD(BPER), .BOOST_HIGH(BHIGH)) i_hbgc_core (
      .sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .avs_response_o(resp), .overtemp_flag_i(flt[0]), .supply_high_flag_i(flt[1]),
      .supply_low_flag_i(flt[2]), .supply_below_boost_on_i(below), .supply_above_boost_off_i(above),
      .bridge_node_one_high_i(n1), .bridge_node_two_high_i(n2), .gate_drive_o(gates),
      .gate_resistive_o(res), .serial_line_off_o(sl_off), .fault_flag_out_o(fl_o),
      .fault_flag_out_oe_o(fl_oe), .upconverter_switch_o(up_o), .upconverter_switch_oe_o(up_oe), .irq_o(irq));

   hbgc_bridge_model i_hbgc_bridge_model (
      .sys_clk_i(clk), .gates_i(gates), .short_gnd_i(sgnd), .short_bat_i(sbat),
      .node_one_high_o(n1), .node_two_high_o(n2));

   task automatic give_verdict;
      if (failures == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Request held until waitrequest is sampled low; read data is taken at that same edge.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q);
      addr <= a; wdata <= d; be <= b; wr <= w; rd <= ~w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      wr <= 1'b0; rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      check_val(what, exp, q);
   endtask

   task automatic wait_gates(input logic [3:0] exp);
      int n;
      n = 0;
      while (gates !== exp && n < QUAL + 8) begin
         n++;
         tick(1);
      end
      check_val("gates", {28'h0, exp}, {28'h0, gates});
   endtask

   task automatic wake;
      wreg(`HBGC_REG_CTRL, 32'h7);
      tick(`HBGC_WAKE_CYC);
      check_val("gates", 32'h5, {28'h0, gates});
      check_val("flag_oe", 32'h0, {31'h0, fl_oe});
   endtask

   task automatic park;
      wreg(`HBGC_REG_CTRL, 32'h7);
      wreg(`HBGC_REG_CTRL, 32'h6);
      tick(1);
      check_val("gates", 32'h0, {28'h0, gates});
      check_val("resistive", 32'h1, {31'h0, res});
      check_val("flag_oe", 32'h0, {31'h0, fl_oe});
   endtask

   task automatic t_reset;
      logic [31:0] q;
      check_val("resistive", 32'h1, {31'h0, res});
      check_val("gates", 32'h0, {28'h0, gates});
      check_val("resp", 32'h0, {30'h0, resp});
      check_val("flag_pin", 32'h0, {31'h0, fl_o});
      check_val("switch_pin", 32'h0, {31'h0, up_o});
      rchk("ctrl", `HBGC_REG_CTRL, `HBGC_CTRL_RST);
      rchk("mask", `HBGC_REG_IRQ_MASK, `HBGC_MASK_RST);
      bus(1'b1, `HBGC_REG_CTRL, 32'h1, 4'hE, q);
      wreg(4'h2, 32'hFF);
      rchk("unmapped", 4'h2, 32'h0);
      rchk("ctrl", `HBGC_REG_CTRL, `HBGC_CTRL_RST);
   endtask

   task automatic t_decode;
      logic [3:0] ctl [4] = '{4'h1, 4'h3, 4'h5, 4'h7};
      logic [3:0] exp [4] = '{4'h6, 4'h9, 4'h5, 4'h5};
      wake;
      for (int i = 0; i < 4; i++) begin
         wreg(`HBGC_REG_CTRL, {28'h0, ctl[i]});
         tick(1);
         check_val("gates", {28'h0, exp[i]}, {28'h0, gates});
         check_val("flag_oe", 32'h0, {31'h0, fl_oe});
         check_val("resistive", 32'h0, {31'h0, res});
      end
      park;
   endtask

   task automatic t_faults;
      for (int i = 0; i < 3; i++) begin
         wake;
         flt[i] <= 1'b1;
         wait_gates(4'h0);
         tick(1);
         check_val("flag_oe", 32'h1, {31'h0, fl_oe});
         check_val("serial_off", {31'h0, i < 2}, {31'h0, sl_off});
         rchk("irq_stat", `HBGC_REG_IRQ_STAT, 32'h1 << i);
         check_val("irq", 32'h0, {31'h0, irq});
         wreg(`HBGC_REG_IRQ_MASK, 32'h1 << i);
         tick(1);
         check_val("irq", 32'h1, {31'h0, irq});
         park;
         flt[i] <= 1'b0;
         wreg(`HBGC_REG_IRQ_STAT, 32'hF);
         wreg(`HBGC_REG_IRQ_MASK, 32'h0);
         check_val("irq", 32'h0, {31'h0, irq});
         rchk("irq_stat", `HBGC_REG_IRQ_STAT, 32'h0);
      end
   endtask

   task automatic t_short;
      wake;
      wreg(`HBGC_REG_CTRL, 32'h1);
      tick(4);
      repeat (2) begin
         sgnd[1] <= 1'b1;
         tick(QUAL - 1);
         sgnd[1] <= 1'b0;
         tick(1);
      end
      check_val("gates", 32'h6, {28'h0, gates});
      sgnd[1] <= 1'b1;
      tick(QUAL);
      check_val("gates", 32'h6, {28'h0, gates});
      wait_gates(4'h4);
      tick(1);
      check_val("flag_oe", 32'h1, {31'h0, fl_oe});
      sgnd[1] <= 1'b0;
      wreg(`HBGC_REG_CTRL, 32'h3);
      tick(1);
      check_val("gates", 32'h9, {28'h0, gates});
      sbat[1] <= 1'b1;
      wait_gates(4'h8);
      tick(1);
      check_val("flag_oe", 32'h1, {31'h0, fl_oe});
      sbat[1] <= 1'b0;
      wreg(`HBGC_REG_CTRL, 32'h7);
      tick(1);
      check_val("gates", 32'h5, {28'h0, gates});
      rchk("irq_stat", `HBGC_REG_IRQ_STAT, 32'h8);
      wreg(`HBGC_REG_IRQ_STAT, 32'hF);
      park;
   endtask

   task automatic boost_chk(input int exp_hi);
      int hi, lo, n;
      hi = 0; lo = 0; n = 0;
      while (up_oe !== 1'b0 && n < 3 * BPER) begin n++; tick(1); end
      while (up_oe !== 1'b1 && n < 3 * BPER) begin n++; tick(1); end
      while (up_oe === 1'b1 && hi < 2 * BPER) begin hi++; tick(1); end
      while (up_oe === 1'b0 && lo < 2 * BPER && exp_hi > 0) begin lo++; tick(1); end
      check_val("boost_high", exp_hi, hi);
      if (exp_hi > 0) check_val("boost_low", BPER - BHIGH, lo);
   endtask

   task automatic t_boost;
      below <= 1'b1;
      boost_chk(BHIGH);
      below <= 1'b0;
      boost_chk(BHIGH);
      above <= 1'b1;
      tick(BPER + 2);
      boost_chk(0);
      above <= 1'b0;
      boost_chk(0);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         give_verdict;
      end
   end

   initial begin
      rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 4'h0; wdata = 32'h0; be = 4'h0;
      flt = 3'h0; below = 1'b0; above = 1'b0; sgnd = 2'h0; sbat = 2'h0;
      failures = 0; total_checks = 0; cycles = 0;
      tick(5);
      rst <= 1'b0;
      tick(1);
      t_reset;
      t_decode;
      t_faults;
      t_short;
      t_boost;
      give_verdict;
   end
endmodule
